// ---- pfc_gate_pkg.sv ----
/*
 * Shared constants and carrier types for the boost converter gate gating logic.
 * Assumes a single 100 MHz clock and comparator outputs already digitised.
 */
package pfc_gate_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OVERSTRESS_HOLD_US = 800;
    localparam int unsigned OVERSTRESS_HOLD_CYC = OVERSTRESS_HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned AUX_OV_STOP_US = 800;
    localparam int unsigned AUX_OV_STOP_CYC = AUX_OV_STOP_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned BLANK_NS = 100;
    localparam int unsigned BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
    localparam int unsigned VALLEY_WAIT_NS = 3000;
    localparam int unsigned VALLEY_WAIT_CYC = VALLEY_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 17;
    localparam int unsigned HIGH_LINE_SHIFT = 2;
    localparam int unsigned CTRL_W = 12;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic overstress;       // sensed current above overstress_current_limit
        logic inrush;           // sensed current above in-rush level
        logic demag_upper;      // demag_sense_pin above demag_upper_threshold
        logic aux_ov;           // demag_sense_pin above aux_overvoltage_threshold
        logic fb_below_boost;   // feedback_pin below undershoot_booster_threshold
    } cmp_t;

    typedef struct packed {
        logic test_current_en;  // 250 uA source on demag_sense_pin
        logic blank_ground;     // turnoff_blanking pull-down
    } demag_pin_ctl_t;

    typedef enum logic [1:0] {
        MODE_CRIT,
        MODE_DISC,
        MODE_CONT
    } conduction_mode_t;

endpackage

// ---- hold_timer.sv ----
/*
 * Retriggerable hold-off counter: busy while trigger is high and for
 * HOLD_CYC cycles after it falls.
 * Assumes trigger comes from logic on mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module hold_timer #(
    parameter int unsigned HOLD_CYC = 80000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic trigger_i,
    output logic busy_o
);
    logic [pfc_gate_pkg::CNT_W-1:0] count_reg;
    logic [pfc_gate_pkg::CNT_W-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (trigger_i) begin
            count_next = HOLD_CYC[pfc_gate_pkg::CNT_W-1:0];
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy_o = trigger_i || (count_reg != '0);
endmodule
`default_nettype wire

// ---- pfc_valley_and_fault_gating.sv ----
/*
 * Gate drive gating for a multimode boost PFC: overstress hold-off,
 * continuous-mode on-time, valley detection, watchdog, demag pin faults,
 * aux overvoltage.
 * Assumes comparator, demag floating and min-frequency ramp inputs are asynchronous pins; cycle_request_i is used unsynchronised.
 */
`timescale 1ns/10ps
`default_nettype none
module pfc_valley_and_fault_gating #(
    parameter bit AUX_OV_PRESENT = 1'b1,
    parameter int unsigned OVERSTRESS_HOLD_CYC = pfc_gate_pkg::OVERSTRESS_HOLD_CYC,
    parameter int unsigned AUX_OV_STOP_CYC = pfc_gate_pkg::AUX_OV_STOP_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire pfc_gate_pkg::cmp_t cmp_i,
    input wire logic demag_floating_i,
    input wire logic line_high_i,
    input wire pfc_gate_pkg::conduction_mode_t mode_i,
    input wire logic inrush_wait_en_i,
    input wire logic cycle_request_i,
    input wire logic min_freq_ramp_i,
    input wire logic [pfc_gate_pkg::CTRL_W-1:0] loop_control_i,
    input wire logic [pfc_gate_pkg::CTRL_W-1:0] current_info_i,
    output logic gate_drive_out_o,
    output pfc_gate_pkg::demag_pin_ctl_t demag_pin_ctl_o,
    output logic [pfc_gate_pkg::CTRL_W-1:0] on_time_setpoint_o,
    output logic valley_enable_o,
    output logic aux_overvoltage_fault_o,
    output logic latched_off_o
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int unsigned NSYNC = 7;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {cmp_i, demag_floating_i, min_freq_ramp_i};

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    pfc_gate_pkg::cmp_t cmp_s;
    logic floating_s;
    logic ramp_s;
    assign cmp_s = sync2_reg[NSYNC-1:2];
    assign floating_s = sync2_reg[1];
    assign ramp_s = sync2_reg[0];

    // ************************************************************
    // overstress and aux overvoltage hold-offs
    // ************************************************************
    logic overstress_active_reg;
    logic overstress_active_next;
    logic overstress_busy;
    logic aux_ov_evt;
    logic aux_ov_busy;

    always_comb begin
        overstress_active_next = overstress_active_reg;
        if (cmp_s.overstress) begin
            overstress_active_next = 1'b1;
        end else if (!cmp_s.inrush) begin
            overstress_active_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            overstress_active_reg <= 1'b0;
        end else begin
            overstress_active_reg <= overstress_active_next;
        end
    end

    // trigger stays high until current falls below in-rush, then 800 us
    hold_timer #(.HOLD_CYC(OVERSTRESS_HOLD_CYC)) u_overstress_hold (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .trigger_i(overstress_active_reg || cmp_s.overstress),
        .busy_o(overstress_busy)
    );

    assign aux_ov_evt = AUX_OV_PRESENT && cmp_s.aux_ov && !demag_pin_ctl_o.blank_ground;

    hold_timer #(.HOLD_CYC(AUX_OV_STOP_CYC)) u_aux_ov_hold (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .trigger_i(aux_ov_evt),
        .busy_o(aux_ov_busy)
    );

    // ************************************************************
    // setpoint scaling
    // ************************************************************
    function automatic logic [pfc_gate_pkg::CTRL_W-1:0] scale_setpoint(
        input logic [pfc_gate_pkg::CTRL_W-1:0] ctrl,
        input logic high_line
    );
        scale_setpoint = high_line ? (ctrl >> pfc_gate_pkg::HIGH_LINE_SHIFT) : ctrl;
    endfunction

    logic [pfc_gate_pkg::CTRL_W-1:0] setpoint_reg;
    logic [pfc_gate_pkg::CTRL_W-1:0] setpoint_next;
    // quarter scaling applies only in continuous mode; valley modes use the full value
    logic scale_en;
    assign scale_en = line_high_i && (mode_i == pfc_gate_pkg::MODE_CONT);

    always_comb begin
        setpoint_next = scale_setpoint(loop_control_i, scale_en);
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            setpoint_reg <= '0;
        end else begin
            setpoint_reg <= setpoint_next;
        end
    end

    // ************************************************************
    // gate state machine
    // ************************************************************
    typedef enum logic [2:0] {
        ST_OFF,
        ST_VALLEY_WAIT,
        ST_TEST,
        ST_ON
    } gate_state_t;

    gate_state_t state_reg;
    gate_state_t state_next;
    logic demag_latch_reg;
    logic demag_latch_next;
    logic latch_off_reg;
    logic latch_off_next;
    logic [pfc_gate_pkg::CTRL_W-1:0] ramp_reg;
    logic [pfc_gate_pkg::CTRL_W-1:0] ramp_next;
    logic [8:0] wait_reg;
    logic [8:0] wait_next;
    logic [3:0] blank_reg;
    logic [3:0] blank_next;
    logic valley;
    logic inhibit;
    logic inrush_ok;
    logic turn_on;
    logic turn_off;
    logic [pfc_gate_pkg::CTRL_W:0] cont_sum;

    assign valley = demag_latch_reg && !cmp_s.demag_upper;
    assign inhibit = overstress_busy || aux_ov_busy || latch_off_reg || floating_s;
    assign inrush_ok = !(inrush_wait_en_i && cmp_s.inrush);
    assign cont_sum = {1'b0, ramp_reg} + {1'b0, current_info_i};

    always_comb begin
        state_next = state_reg;
        ramp_next = ramp_reg;
        wait_next = wait_reg;
        turn_on = 1'b0;
        turn_off = 1'b0;
        case (state_reg)
            ST_OFF: begin
                if (!inhibit) begin
                    if (mode_i == pfc_gate_pkg::MODE_CONT) begin
                        turn_on = cycle_request_i;
                    end else if (valley && inrush_ok && (cycle_request_i || ramp_s)) begin
                        turn_on = 1'b1;
                    end else if (ramp_s) begin
                        state_next = ST_VALLEY_WAIT;
                        wait_next = 9'(pfc_gate_pkg::VALLEY_WAIT_CYC);
                    end
                end
            end
            ST_VALLEY_WAIT: begin
                if (wait_reg != '0) begin
                    wait_next = wait_reg - 1'b1;
                end
                if (inhibit) begin
                    state_next = ST_OFF;
                end else if (valley && inrush_ok) begin
                    turn_on = 1'b1;
                end else if (wait_reg == '0) begin
                    state_next = ST_TEST;
                end
            end
            ST_TEST: begin
                // a grounded pin never crosses, so switching stays inhibited
                if (inhibit) begin
                    state_next = ST_OFF;
                end else if (cmp_s.demag_upper) begin
                    turn_on = 1'b1;
                end
            end
            ST_ON: begin
                ramp_next = ramp_reg + 1'b1;
                if (inhibit || cmp_s.overstress) begin
                    turn_off = 1'b1;
                end else if (mode_i == pfc_gate_pkg::MODE_CONT) begin
                    turn_off = cont_sum >= {1'b0, setpoint_reg};
                end else begin
                    turn_off = !cycle_request_i;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (turn_on) begin
            state_next = ST_ON;
            ramp_next = '0;
        end
        if (turn_off) begin
            state_next = ST_OFF;
        end
    end

    always_comb begin
        demag_latch_next = demag_latch_reg;
        if (turn_on) begin
            demag_latch_next = 1'b0;
        end else if (cmp_s.demag_upper && state_reg != ST_ON && state_reg != ST_TEST) begin
            demag_latch_next = 1'b1;
        end
        latch_off_next = latch_off_reg;
        if (aux_ov_evt && cmp_s.fb_below_boost) begin
            latch_off_next = 1'b1;
        end
        blank_next = blank_reg;
        if (turn_off) begin
            blank_next = 4'(pfc_gate_pkg::BLANK_CYC);
        end else if (blank_reg != '0) begin
            blank_next = blank_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_OFF;
            ramp_reg <= '0;
            wait_reg <= '0;
            demag_latch_reg <= 1'b0;
            latch_off_reg <= 1'b0;
            blank_reg <= '0;
        end else begin
            state_reg <= state_next;
            ramp_reg <= ramp_next;
            wait_reg <= wait_next;
            demag_latch_reg <= demag_latch_next;
            latch_off_reg <= latch_off_next;
            blank_reg <= blank_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic drive_reg;
    logic fault_reg;
    logic valley_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            drive_reg <= 1'b0;
            fault_reg <= 1'b0;
            valley_reg <= 1'b0;
        end else begin
            drive_reg <= (state_next == ST_ON);
            fault_reg <= aux_ov_busy;
            valley_reg <= valley;
        end
    end

    assign gate_drive_out_o = drive_reg;
    assign demag_pin_ctl_o.blank_ground = blank_reg != '0;
    assign demag_pin_ctl_o.test_current_en = state_reg == ST_TEST;
    assign on_time_setpoint_o = setpoint_reg;
    assign valley_enable_o = valley_reg;
    assign aux_overvoltage_fault_o = fault_reg;
    assign latched_off_o = latch_off_reg;
endmodule
`default_nettype wire

// ---- pfc_gate_properties.sv ----
/* Concurrent checks on the gate gating block.
   Bound to every instance; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module pfc_gate_properties #(
    parameter int unsigned AUX_OV_STOP_CYC = 50
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire pfc_gate_pkg::cmp_t cmp_i,
    input wire logic demag_floating_i,
    input wire logic line_high_i,
    input wire pfc_gate_pkg::conduction_mode_t mode_i,
    input wire logic [pfc_gate_pkg::CTRL_W-1:0] loop_control_i,
    input wire logic gate_drive_out_o,
    input wire pfc_gate_pkg::demag_pin_ctl_t demag_pin_ctl_o,
    input wire logic [pfc_gate_pkg::CTRL_W-1:0] on_time_setpoint_o,
    input wire logic valley_enable_o,
    input wire logic aux_overvoltage_fault_o,
    input wire logic latched_off_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_turn_off;
        $fell(gate_drive_out_o);
    endsequence
    sequence s_blank;
        ##[0:1] demag_pin_ctl_o.blank_ground [*8];
    endsequence
    a_blank_after_off: assert property (s_turn_off |-> s_blank)
        else $error("blanking missing after turn-off");
    a_latch_gate_low: assert property (
        latched_off_o && $past(latched_off_o) |-> !gate_drive_out_o)
        else $error("drive on while latched off");
    a_latch_sticky: assert property (latched_off_o |=> latched_off_o)
        else $error("latch-off released without reset");
    a_fault_gate_low: assert property (
        aux_overvoltage_fault_o && $past(aux_overvoltage_fault_o) |-> !gate_drive_out_o)
        else $error("drive on during overvoltage stop");
    a_fault_min_len: assert property (
        $rose(aux_overvoltage_fault_o) |-> aux_overvoltage_fault_o [*8])
        else $error("overvoltage stop too short");
    a_setpoint_scale: assert property (
        $past(rst_n_i) && $past(mode_i) == pfc_gate_pkg::MODE_CONT |-> on_time_setpoint_o ==
        ($past(line_high_i) ? $past(loop_control_i) >> pfc_gate_pkg::HIGH_LINE_SHIFT
        : $past(loop_control_i)))
        else $error("setpoint scaling wrong");
    a_setpoint_full: assert property (
        $past(rst_n_i) && $past(mode_i) != pfc_gate_pkg::MODE_CONT
        |-> on_time_setpoint_o == $past(loop_control_i))
        else $error("setpoint scaled outside continuous mode");
    a_overstress_low: assert property (cmp_i.overstress [*5] |-> !gate_drive_out_o)
        else $error("drive on during overstress");
    a_float_no_on: assert property (demag_floating_i [*6] |=> !$rose(gate_drive_out_o))
        else $error("turn-on with floating demag pin");
    a_pulse_clears_valley: assert property (
        $rose(gate_drive_out_o) |-> ##[0:2] !valley_enable_o)
        else $error("valley enable not cleared by pulse");
    a_test_no_drive: assert property (
        demag_pin_ctl_o.test_current_en && $past(demag_pin_ctl_o.test_current_en)
        |-> !gate_drive_out_o)
        else $error("drive on during pin test");
endmodule
bind pfc_valley_and_fault_gating pfc_gate_properties #(.AUX_OV_STOP_CYC(AUX_OV_STOP_CYC)) chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i), .demag_floating_i(demag_floating_i),
    .line_high_i(line_high_i), .mode_i(mode_i), .loop_control_i(loop_control_i),
    .gate_drive_out_o(gate_drive_out_o), .demag_pin_ctl_o(demag_pin_ctl_o),
    .on_time_setpoint_o(on_time_setpoint_o), .valley_enable_o(valley_enable_o),
    .aux_overvoltage_fault_o(aux_overvoltage_fault_o), .latched_off_o(latched_off_o));
`default_nettype wire

// ---- power_stage_model.sv ----
/* Boost stage and auxiliary winding seen at the demag pin comparators.
   Assumes the gate drive and pin controls of the block on the same clock. */
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
    input wire logic mclk_i,
    input wire logic gate_i,
    input wire logic test_i,
    input wire logic blank_i,
    input wire logic gnd_i,
    input wire logic ov_i,
    output logic upper_o,
    output logic aux_ov_o
);
    int demag_cnt = 0;
    // core resets for a fixed time after every on-time
    always @(posedge mclk_i) begin
        if (gate_i)
            demag_cnt <= 20;
        else if (demag_cnt > 0)
            demag_cnt <= demag_cnt - 1;
    end
    // a shorted pin stays low even with the test current on
    assign upper_o = !blank_i && !gnd_i && !gate_i && (demag_cnt > 0 || test_i);
    assign aux_ov_o = upper_o && ov_i;
endmodule
`default_nettype wire

// ---- testbench.sv ----
/* Self-checking bench for the gate gating block.
   Comparators and loop data come from here; the stage model answers on the demag pin. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int unsigned HOLD = 50;
    logic mclk = 0;
    logic rst_n = 0;
    logic os = 0, ir = 0, fbl = 0, ov = 0, gnd = 0, flt = 0, lh = 0, req = 0, ramp = 0, iwe = 0;
    pfc_gate_pkg::conduction_mode_t mode = pfc_gate_pkg::MODE_CONT;
    logic [11:0] loopc = 12'h000, cur = 12'h000, sp;
    logic [7:0] on_cnt = 8'h00;
    logic up, aov, gate, valley, fault, latched;
    pfc_gate_pkg::demag_pin_ctl_t pin;
    int n_fail = 0, num_checks = 0, i, n, spx;
    always #5 mclk = ~mclk;
    power_stage_model stage (.mclk_i(mclk), .gate_i(gate), .test_i(pin.test_current_en),
        .blank_i(pin.blank_ground), .gnd_i(gnd), .ov_i(ov), .upper_o(up), .aux_ov_o(aov));
    pfc_valley_and_fault_gating #(.OVERSTRESS_HOLD_CYC(HOLD), .AUX_OV_STOP_CYC(HOLD)) dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .cmp_i(pfc_gate_pkg::cmp_t'({os, ir, up, aov, fbl})),
        .demag_floating_i(flt), .line_high_i(lh), .mode_i(mode), .inrush_wait_en_i(iwe),
        .cycle_request_i(req), .min_freq_ramp_i(ramp), .loop_control_i(loopc),
        .current_info_i(cur), .gate_drive_out_o(gate), .demag_pin_ctl_o(pin),
        .on_time_setpoint_o(sp), .valley_enable_o(valley),
        .aux_overvoltage_fault_o(fault), .latched_off_o(latched));
    // loop asks for a 30-cycle on-time in valley modes
    always @(negedge mclk) begin
        on_cnt <= gate ? on_cnt + 8'h01 : 8'h00;
        req <= mode == pfc_gate_pkg::MODE_CONT || !gate || on_cnt < 8'h1E;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic sig(input int k);
        logic [3:0] v;
        v = {latched, pin.test_current_en, fault, gate};
        return v[k];
    endfunction
    // bounded wait: 0 drive, 1 fault, 2 test current, 3 latch-off; cycles waited in n
    task automatic wt(input int k, input logic v, input int lim);
        n = 0;
        while (sig(k) !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
        chk(sig(k), v);
        if (sig(k) !== v)
            tally_and_finish;
    endtask
    initial begin
        n = $urandom(32'h31271995);
        repeat (3) @(negedge mclk);
        rst_n = 1;
        repeat (2) @(negedge mclk);
        for (i = 0; i < 16; i++) begin
            loopc = 12'($urandom);
            cur = 12'($urandom);
            lh = 1'($urandom);
            @(negedge mclk);
            chk(sp, lh ? loopc >> 2 : loopc);
        end
        wt(0, 0, 10000);
        wt(0, 1, 50);
        spx = lh ? int'(loopc >> 2) : int'(loopc);
        wt(0, 0, 10000);
        chk(n, (spx > int'(cur) ? spx - int'(cur) : 0) + 1);
        mode = pfc_gate_pkg::MODE_CRIT;
        wt(0, 0, 10000);
        wt(0, 1, 200);
        mode = pfc_gate_pkg::MODE_DISC;
        wt(0, 0, 200);
        iwe = 1;
        ir = 1;
        n = 0;
        for (i = 0; i < 60; i++) begin
            @(negedge mclk);
            n += gate;
        end
        chk(n, 0);
        chk(valley, 1);
        ir = 0;
        wt(0, 1, 20);
        iwe = 0;
        wt(0, 1, 200);
        os = 1;
        ir = 1;
        repeat (6) @(negedge mclk);
        chk(gate, 0);
        os = 0;
        repeat (10) @(negedge mclk);
        ir = 0;
        wt(0, 1, HOLD + 40);
        chk(n >= HOLD, 1);
        wt(0, 0, 100);
        flt = 1;
        repeat (6) @(negedge mclk);
        n = 0;
        for (i = 0; i < 200; i++) begin
            @(negedge mclk);
            n += gate;
        end
        chk(n, 0);
        flt = 0;
        gnd = 1;
        repeat (60) @(negedge mclk);
        wt(0, 0, 100);
        ramp = 1;
        repeat (4) @(negedge mclk);
        ramp = 0;
        wt(2, 1, 400);
        chk(n >= 290, 1);
        repeat (50) @(negedge mclk);
        chk(gate, 0);
        gnd = 0;
        wt(0, 1, 100);
        ov = 1;
        wt(1, 1, 300);
        ov = 0;
        wt(1, 0, 300);
        chk(n >= HOLD - 2, 1);
        fbl = 1;
        ov = 1;
        wt(3, 1, 400);
        ov = 0;
        fbl = 0;
        repeat (100) @(negedge mclk);
        chk({latched, gate}, 2'b10);
        rst_n = 0;
        repeat (3) @(negedge mclk);
        rst_n = 1;
        chk(latched, 0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
